// ==== core/pid_params.svh ====
// named constants of the cascaded regulator: register map, ranges, resets, timing
// included by the regulator, the monitor and the testbench; definitions only
`ifndef CASCADED_PID_PARAMS_SVH
`define CASCADED_PID_PARAMS_SVH

// timing
`define CLK_MHZ           125
`define SAMPLE_PERIOD_US  50
`define OUTER_RATIO       2'h3
// register byte offsets
`define REG_CTRL          8'h00
`define REG_SETPOINT      8'h04
`define REG_OUTER_BASE    8'h08
`define REG_INNER_BASE    8'h28
`define REG_ZTR_GAIN      8'h48
`define REG_ZTR_AMP       8'h4c
`define REG_MACH_ADDR     8'h50
`define REG_PWR_ADDR      8'h54
`define REG_MAINS_V       8'h58
`define REG_DCBUS_V       8'h5c
`define REG_HS_TEMP       8'h60
`define REG_IRQ_STATUS    8'h64
`define REG_IRQ_CLEAR     8'h68
`define REG_IRQ_ENABLE    8'h6c
`define REG_CUR_REF       8'h70
`define REG_MOD_OUT       8'h74
// offsets inside a stage block
`define STG_KP            5'h00
`define STG_TI            5'h04
`define STG_TD            5'h08
`define STG_ILIM_HI       5'h0c
`define STG_ILIM_LO       5'h10
`define STG_DLIM_HI       5'h14
`define STG_DLIM_LO       5'h18
`define STG_SPAN          8'h1c
// control fields
`define CTRL_RUN          0
`define CTRL_OUTER_SCALED 1
`define CTRL_INNER_SCALED 2
// setting ranges
`define KP_MAX            32'h0000_2710
`define TIME_MAX_US       32'h0000_7d00
`define PCT_MAX           32'h0000_0064
`define ZTR_MAX           32'h0000_0064
// reset values
`define KP_RST            14'h0064
`define PCT_RST           7'h64
`define ADDR_RST          8'h01
// arithmetic scaling
`define FULL_SCALE        48'sh0000_0000_7fff
`define KP_SHIFT          7
`define ZTR_SHIFT         4
`define ZTR_BAND          48'sh0000_0000_0148
// interrupt status layout: alarms in [7:0], modulator update in [8]
`define IRQ_W             9
`define IRQ_UPDATE        8
`define ALARM_CLEARABLE   9'h1df

`endif

// ==== core/pid_pkg.sv ====
// types shared by the cascaded regulator
// constants live in pid_params.svh
package pid_pkg;

   typedef logic signed [47:0] wide_t;

   typedef struct packed {
      logic [13:0] kp;
      logic [14:0] ti;
      logic [14:0] td;
      logic [6:0]  ilim_hi;
      logic [6:0]  ilim_lo;
      logic [6:0]  dlim_hi;
      logic [6:0]  dlim_lo;
      logic        scaled;
   } stage_cfg_s;

endpackage

// ==== core/cascaded_pid_regulator.sv ====
// cascaded voltage/current regulator with zero-crossing compensation and apb registers
// assumes apb master on I_MCLK and measurements synchronous to I_MCLK
`timescale 1ns/100ps
`include "pid_params.svh"

module pid_stage (
   input  wire logic                clk,     // system clock
   input  wire logic                rst_n,   // async reset, active low
   input  wire logic                upd,     // one-cycle update strobe
   input  wire logic signed [15:0]  ref_in,  // reference
   input  wire logic signed [15:0]  fb_in,   // feedback
   input  pid_pkg::stage_cfg_s      cfg,     // settings
   output logic signed [15:0]       y        // stage result
);
   pid_pkg::wide_t acc;
   pid_pkg::wide_t prev_err;
   pid_pkg::wide_t err;
   pid_pkg::wide_t kp;
   pid_pkg::wide_t dt;
   pid_pkg::wide_t ti_eff;
   pid_pkg::wide_t td_eff;
   pid_pkg::wide_t p_term;
   pid_pkg::wide_t i_inc;
   pid_pkg::wide_t i_next;
   pid_pkg::wide_t d_term;
   pid_pkg::wide_t total;

   function automatic pid_pkg::wide_t pct(input logic [6:0] p);
      pct = (pid_pkg::wide_t'({1'b0, p}) * `FULL_SCALE) / pid_pkg::wide_t'(`PCT_MAX);
   endfunction

   function automatic pid_pkg::wide_t clamp(input pid_pkg::wide_t v,
                                           input pid_pkg::wide_t lo,
                                           input pid_pkg::wide_t hi);
      clamp = (v > hi) ? hi : ((v < lo) ? lo : v);
   endfunction

   assign err    = pid_pkg::wide_t'(ref_in) - pid_pkg::wide_t'(fb_in);
   assign kp     = pid_pkg::wide_t'({1'b0, cfg.kp});
   assign dt     = pid_pkg::wide_t'(`SAMPLE_PERIOD_US);
   assign p_term = (err * kp) >>> `KP_SHIFT;
   // gain-scaled times keep the same fixed point as the proportional path
   assign ti_eff = cfg.scaled ? ((pid_pkg::wide_t'({1'b0, cfg.ti}) * kp) >>> `KP_SHIFT)
                              : pid_pkg::wide_t'({1'b0, cfg.ti});
   assign td_eff = cfg.scaled ? ((pid_pkg::wide_t'({1'b0, cfg.td}) * kp) >>> `KP_SHIFT)
                              : pid_pkg::wide_t'({1'b0, cfg.td});
   assign i_inc  = (ti_eff == 48'sh0) ? 48'sh0 : (err * dt) / ti_eff;
   assign i_next = (cfg.ti == 15'h0) ? 48'sh0
                 : clamp(acc + i_inc, -pct(cfg.ilim_lo), pct(cfg.ilim_hi));
   assign d_term = (cfg.td == 15'h0) ? 48'sh0
                 : clamp(((err - prev_err) * td_eff) / dt,
                         -pct(cfg.dlim_lo), pct(cfg.dlim_hi));
   assign total  = clamp(p_term + i_next + d_term, -`FULL_SCALE, `FULL_SCALE);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         acc      <= 48'sh0;
         prev_err <= 48'sh0;
         y        <= 16'sh0;
      end else if (upd) begin
         acc      <= i_next;
         prev_err <= err;
         y        <= total[15:0];
      end
   end
endmodule

module cascaded_pid_regulator #(
   parameter int SAMPLE_CYCLES = `SAMPLE_PERIOD_US * `CLK_MHZ
) (
   input  wire logic               I_MCLK,         // 125 MHz clock
   input  wire logic               I_RST_N,        // async reset, active low
   input  wire logic               I_PSEL,         // apb select
   input  wire logic               I_PENABLE,      // apb access phase
   input  wire logic               I_PWRITE,       // apb write
   input  wire logic [7:0]         I_PADDR,        // apb byte address
   input  wire logic [31:0]        I_PWDATA,       // apb write data
   input  wire logic signed [15:0] I_VOUT,         // measured output voltage
   input  wire logic signed [15:0] I_IOUT,         // measured output current
   input  wire logic [15:0]        I_MAINS_V,      // mains voltage reading
   input  wire logic [15:0]        I_DCBUS_V,      // dc bus voltage reading
   input  wire logic [15:0]        I_HS_TEMP,      // heat-sink temperature
   input  wire logic [7:0]         I_ALARM,        // alarm conditions, high active
   output logic                    O_PREADY,       // apb ready
   output logic [31:0]             O_PRDATA,       // apb read data
   output logic                    O_PSLVERR,      // apb error, unmapped address
   output logic signed [15:0]      O_MOD,          // modulator drive
   output logic                    O_MOD_VALID,    // pulse with new drive
   output logic [7:0]              O_MACHINE_ADDR, // serial machine address
   output logic [7:0]              O_POWER_ADDR,   // power module address
   output logic                    O_IRQ           // interrupt, high active
);
   logic [2:0]              ctrl;
   logic signed [15:0]      setpoint;
   pid_pkg::stage_cfg_s     cfg [2];
   logic [6:0]              ztr_gain;
   logic [6:0]              ztr_amp;
   logic [15:0]             mains_v;
   logic [15:0]             dcbus_v;
   logic [15:0]             hs_temp;
   logic [`IRQ_W-1:0]       irq_status;
   logic [`IRQ_W-1:0]       irq_enable;
   logic [15:0]             tick_cnt;
   logic [1:0]              outer_cnt;
   logic                    inner_upd;
   logic                    mod_upd;
   logic signed [15:0]      cur_ref;
   logic signed [15:0]      inner_y;

   wire        acc_phase = I_PSEL & I_PENABLE;
   wire        wr        = acc_phase & O_PREADY & I_PWRITE;
   wire        run       = ctrl[`CTRL_RUN];
   wire        tick      = run & (tick_cnt == 16'(SAMPLE_CYCLES - 1));
   wire        outer_upd = tick & (outer_cnt == `OUTER_RATIO);
   wire        in_outer  = (I_PADDR >= `REG_OUTER_BASE)
                         & (I_PADDR < `REG_OUTER_BASE + `STG_SPAN);
   wire        in_inner  = (I_PADDR >= `REG_INNER_BASE)
                         & (I_PADDR < `REG_INNER_BASE + `STG_SPAN);
   wire [4:0]  stg_off   = in_outer ? 5'(I_PADDR - `REG_OUTER_BASE)
                                    : 5'(I_PADDR - `REG_INNER_BASE);
   wire        stg_word  = stg_off[1:0] == 2'h0;

   function automatic logic [31:0] lim(input logic [31:0] v, input logic [31:0] mx);
      lim = (v > mx) ? mx : v;
   endfunction

   function automatic logic [14:0] tlim(input logic [31:0] v);
      if (v == 32'h0)
         tlim = 15'h0;
      else if (v < 32'(`SAMPLE_PERIOD_US))
         tlim = 15'(`SAMPLE_PERIOD_US);
      else
         tlim = 15'(lim(v, `TIME_MAX_US));
   endfunction

   function automatic logic [31:0] stg_rd(input pid_pkg::stage_cfg_s c, input logic [4:0] o);
      unique case (o)
         `STG_KP:      stg_rd = {18'h0, c.kp};
         `STG_TI:      stg_rd = {17'h0, c.ti};
         `STG_TD:      stg_rd = {17'h0, c.td};
         `STG_ILIM_HI: stg_rd = {25'h0, c.ilim_hi};
         `STG_ILIM_LO: stg_rd = {25'h0, c.ilim_lo};
         `STG_DLIM_HI: stg_rd = {25'h0, c.dlim_hi};
         `STG_DLIM_LO: stg_rd = {25'h0, c.dlim_lo};
         default:      stg_rd = 32'h0;
      endcase
   endfunction

   wire mapped = in_outer ? stg_word
               : in_inner ? stg_word
               : (I_PADDR == `REG_CTRL) | (I_PADDR == `REG_SETPOINT)
               | (I_PADDR == `REG_ZTR_GAIN) | (I_PADDR == `REG_ZTR_AMP)
               | (I_PADDR == `REG_MACH_ADDR) | (I_PADDR == `REG_PWR_ADDR)
               | (I_PADDR == `REG_MAINS_V) | (I_PADDR == `REG_DCBUS_V)
               | (I_PADDR == `REG_HS_TEMP) | (I_PADDR == `REG_IRQ_STATUS)
               | (I_PADDR == `REG_IRQ_CLEAR) | (I_PADDR == `REG_IRQ_ENABLE)
               | (I_PADDR == `REG_CUR_REF) | (I_PADDR == `REG_MOD_OUT);

   // settings read back as stored
   wire [31:0] rd_data =
        in_outer                        ? stg_rd(cfg[0], stg_off)
      : in_inner                        ? stg_rd(cfg[1], stg_off)
      : (I_PADDR == `REG_CTRL)          ? {29'h0, ctrl}
      : (I_PADDR == `REG_SETPOINT)      ? {{16{setpoint[15]}}, setpoint}
      : (I_PADDR == `REG_ZTR_GAIN)      ? {25'h0, ztr_gain}
      : (I_PADDR == `REG_ZTR_AMP)       ? {25'h0, ztr_amp}
      : (I_PADDR == `REG_MACH_ADDR)     ? {24'h0, O_MACHINE_ADDR}
      : (I_PADDR == `REG_PWR_ADDR)      ? {24'h0, O_POWER_ADDR}
      : (I_PADDR == `REG_MAINS_V)       ? {16'h0, mains_v}
      : (I_PADDR == `REG_DCBUS_V)       ? {16'h0, dcbus_v}
      : (I_PADDR == `REG_HS_TEMP)       ? {16'h0, hs_temp}
      : (I_PADDR == `REG_IRQ_STATUS)    ? {23'h0, irq_status}
      : (I_PADDR == `REG_IRQ_ENABLE)    ? {23'h0, irq_enable}
      : (I_PADDR == `REG_CUR_REF)       ? {{16{cur_ref[15]}}, cur_ref}
      : (I_PADDR == `REG_MOD_OUT)       ? {{16{O_MOD[15]}}, O_MOD}
      : 32'h0;

   // apb: one wait state, data and error registered with pready
   always_ff @(posedge I_MCLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         O_PREADY  <= 1'b0;
         O_PRDATA  <= 32'h0;
         O_PSLVERR <= 1'b0;
      end else begin
         O_PREADY  <= acc_phase & ~O_PREADY;
         O_PRDATA  <= (acc_phase & ~O_PREADY & ~I_PWRITE & mapped) ? rd_data : 32'h0;
         O_PSLVERR <= acc_phase & ~O_PREADY & ~mapped;
      end
   end

   // software settings, clipped to their documented ranges on write
   always_ff @(posedge I_MCLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         ctrl           <= 3'h0;
         setpoint       <= 16'sh0;
         ztr_gain       <= 7'h0;
         ztr_amp        <= 7'h0;
         O_MACHINE_ADDR <= `ADDR_RST;
         O_POWER_ADDR   <= `ADDR_RST;
         irq_enable     <= 9'h0;
         for (int s = 0; s < 2; s++) begin
            cfg[s] <= '{kp: `KP_RST, ti: 15'h0, td: 15'h0, ilim_hi: `PCT_RST,
                        ilim_lo: `PCT_RST, dlim_hi: `PCT_RST, dlim_lo: `PCT_RST,
                        scaled: 1'b0};
         end
      end else begin
         cfg[0].scaled <= ctrl[`CTRL_OUTER_SCALED];
         cfg[1].scaled <= ctrl[`CTRL_INNER_SCALED];
         if (wr) begin
            for (int s = 0; s < 2; s++) begin
               if ((s == 0 ? in_outer : in_inner) & stg_word) begin
                  unique case (stg_off)
                     `STG_KP:      cfg[s].kp      <= 14'(lim(I_PWDATA, `KP_MAX));
                     `STG_TI:      cfg[s].ti      <= tlim(I_PWDATA);
                     `STG_TD:      cfg[s].td      <= tlim(I_PWDATA);
                     `STG_ILIM_HI: cfg[s].ilim_hi <= 7'(lim(I_PWDATA, `PCT_MAX));
                     `STG_ILIM_LO: cfg[s].ilim_lo <= 7'(lim(I_PWDATA, `PCT_MAX));
                     `STG_DLIM_HI: cfg[s].dlim_hi <= 7'(lim(I_PWDATA, `PCT_MAX));
                     `STG_DLIM_LO: cfg[s].dlim_lo <= 7'(lim(I_PWDATA, `PCT_MAX));
                     default:      cfg[s].kp      <= cfg[s].kp;
                  endcase
               end
            end
            if (I_PADDR == `REG_CTRL)
               ctrl <= I_PWDATA[2:0];
            if (I_PADDR == `REG_SETPOINT)
               setpoint <= I_PWDATA[15:0];
            if (I_PADDR == `REG_ZTR_GAIN)
               ztr_gain <= 7'(lim(I_PWDATA, `ZTR_MAX));
            if (I_PADDR == `REG_ZTR_AMP)
               ztr_amp <= 7'(lim(I_PWDATA, `ZTR_MAX));
            if (I_PADDR == `REG_MACH_ADDR)
               O_MACHINE_ADDR <= I_PWDATA[7:0];
            if (I_PADDR == `REG_PWR_ADDR)
               O_POWER_ADDR <= I_PWDATA[7:0];
            if (I_PADDR == `REG_IRQ_ENABLE)
               irq_enable <= I_PWDATA[`IRQ_W-1:0];
         end
      end
   end

   // fixed sample period, no register reaches this count
   always_ff @(posedge I_MCLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         tick_cnt  <= 16'h0;
         outer_cnt <= 2'h0;
         inner_upd <= 1'b0;
         mod_upd   <= 1'b0;
      end else begin
         tick_cnt  <= (!run | tick) ? 16'h0 : tick_cnt + 16'h1;
         outer_cnt <= tick ? outer_cnt + 2'h1 : outer_cnt;
         inner_upd <= tick;
         mod_upd   <= inner_upd;
      end
   end

   pid_stage u_outer (
      .clk    (I_MCLK),
      .rst_n  (I_RST_N),
      .upd    (outer_upd),
      .ref_in (setpoint),
      .fb_in  (I_VOUT),
      .cfg    (cfg[0]),
      .y      (cur_ref)
   );

   // inner runs one cycle after the outer so it sees the fresh reference
   pid_stage u_inner (
      .clk    (I_MCLK),
      .rst_n  (I_RST_N),
      .upd    (inner_upd),
      .ref_in (cur_ref),
      .fb_in  (I_IOUT),
      .cfg    (cfg[1]),
      .y      (inner_y)
   );

   // zero-crossing compensation on the inner error
   wire pid_pkg::wide_t i_cur   = pid_pkg::wide_t'(I_IOUT);
   wire pid_pkg::wide_t i_err   = pid_pkg::wide_t'(cur_ref) - i_cur;
   wire                 near_0  = (i_cur < `ZTR_BAND) & (i_cur > -`ZTR_BAND);
   wire pid_pkg::wide_t amp     = (pid_pkg::wide_t'({1'b0, ztr_amp}) * `FULL_SCALE)
                                / pid_pkg::wide_t'(`ZTR_MAX);
   wire pid_pkg::wide_t raw     = (i_err * pid_pkg::wide_t'({1'b0, ztr_gain})) >>> `ZTR_SHIFT;
   wire pid_pkg::wide_t corr    = !near_0 ? 48'sh0
                                : (raw > amp) ? amp : ((raw < -amp) ? -amp : raw);
   wire pid_pkg::wide_t mod_sum = pid_pkg::wide_t'(inner_y) + corr;
   wire pid_pkg::wide_t mod_sat = (mod_sum > `FULL_SCALE) ? `FULL_SCALE
                                : ((mod_sum < -`FULL_SCALE) ? -`FULL_SCALE : mod_sum);

   wire [`IRQ_W-1:0] irq_set = {mod_upd, I_ALARM};
   wire [`IRQ_W-1:0] irq_clr = (wr & (I_PADDR == `REG_IRQ_CLEAR))
                             ? (I_PWDATA[`IRQ_W-1:0] & `ALARM_CLEARABLE) : 9'h0;

   always_ff @(posedge I_MCLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         O_MOD       <= 16'sh0;
         O_MOD_VALID <= 1'b0;
         mains_v     <= 16'h0;
         dcbus_v     <= 16'h0;
         hs_temp     <= 16'h0;
         irq_status  <= 9'h0;
         O_IRQ       <= 1'b0;
      end else begin
         if (mod_upd)
            O_MOD <= mod_sat[15:0];
         O_MOD_VALID <= mod_upd;
         mains_v     <= I_MAINS_V;
         dcbus_v     <= I_DCBUS_V;
         hs_temp     <= I_HS_TEMP;
         // a new event wins over a clear in the same cycle
         irq_status  <= (irq_status & ~irq_clr) | irq_set;
         O_IRQ       <= |(irq_status & irq_enable);
      end
   end
endmodule

// ==== verif/pwm_stage_model.sv ====
// behavioural modulator and power stage closing the regulation loop
// assumes new drive arrives as one-cycle valid pulses on the block clock
`timescale 1ns/100ps
module pwm_stage_model (
   input  wire logic               i_clk,   // clock
   input  wire logic signed [15:0] i_mod,   // drive
   input  wire logic               i_valid, // new drive
   input  wire logic               i_hold,  // pin feedback
   input  wire logic signed [15:0] i_vset,  // pinned voltage
   input  wire logic signed [15:0] i_iset,  // pinned current
   output logic signed [15:0]      o_vout,  // voltage
   output logic signed [15:0]      o_iout   // current
);
   logic signed [15:0] cur;
   initial cur = 16'sh0;
   // current lags the drive by a quarter step each update
   always @(posedge i_clk) begin
      if (i_valid) begin
         cur <= cur + ((i_mod >>> 1) - (cur >>> 1)) / 2;
      end
   end
   assign o_vout = i_hold ? i_vset : cur >>> 1;
   assign o_iout = i_hold ? i_iset : cur;
endmodule

// ==== verif/pid_regulator_monitor.sv ====
// port assertions for the cascaded regulator
// assumes an apb master that holds the request until pready
`timescale 1ns/100ps
`include "pid_params.svh"
module pid_regulator_monitor #(
   parameter int SAMPLE_CYCLES = 6250
) (
   input wire logic               I_MCLK,         // clock
   input wire logic               I_RST_N,        // reset
   input wire logic               I_PSEL,         // select
   input wire logic               I_PENABLE,      // access
   input wire logic               I_PWRITE,       // write
   input wire logic [7:0]         I_PADDR,        // address
   input wire logic [31:0]        I_PWDATA,       // wdata
   input wire logic signed [15:0] I_VOUT,         // voltage
   input wire logic signed [15:0] I_IOUT,         // current
   input wire logic [15:0]        I_MAINS_V,      // mains
   input wire logic [15:0]        I_DCBUS_V,      // bus
   input wire logic [15:0]        I_HS_TEMP,      // temp
   input wire logic [7:0]         I_ALARM,        // alarms
   input wire logic               O_PREADY,       // ready
   input wire logic [31:0]        O_PRDATA,       // rdata
   input wire logic               O_PSLVERR,      // error
   input wire logic signed [15:0] O_MOD,          // drive
   input wire logic               O_MOD_VALID,    // new drive
   input wire logic [7:0]         O_MACHINE_ADDR, // address
   input wire logic [7:0]         O_POWER_ADDR,   // power address
   input wire logic               O_IRQ           // interrupt
);
   default clocking cb @(posedge I_MCLK); endclocking
   default disable iff (!I_RST_N);
   logic [31:0] gap;
   logic        seen;
   // cycles since the last drive update
   always_ff @(posedge I_MCLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         gap  <= 32'h0;
         seen <= 1'b0;
      end else begin
         gap  <= O_MOD_VALID ? 32'h0 : gap + 32'h1;
         seen <= seen | O_MOD_VALID;
      end
   end
   property p_ready_wait;
      $rose(I_PENABLE) && I_PSEL |-> !O_PREADY ##1 O_PREADY;
   endproperty
   a_ready_wait: assert property (p_ready_wait) else $error("ready not after one wait");
   property p_ready_cause;
      O_PREADY |-> I_PSEL && I_PENABLE && $past(I_PSEL && I_PENABLE);
   endproperty
   a_ready_cause: assert property (p_ready_cause) else $error("ready without access");
   property p_rdata_idle;
      !O_PREADY |-> O_PRDATA == 32'h0;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside ready");
   property p_err_unmapped;
      O_PREADY && I_PADDR >= 8'h78 |-> O_PSLVERR && O_PRDATA == 32'h0;
   endproperty
   a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped not refused");
   property p_valid_pulse;
      O_MOD_VALID |=> !O_MOD_VALID;
   endproperty
   a_valid_pulse: assert property (p_valid_pulse) else $error("valid too long");
   property p_mod_hold;
      !O_MOD_VALID |-> $stable(O_MOD);
   endproperty
   a_mod_hold: assert property (p_mod_hold) else $error("drive moved between updates");
   property p_period;
      O_MOD_VALID && seen |-> gap == SAMPLE_CYCLES - 1;
   endproperty
   a_period: assert property (p_period) else $error("update spacing wrong");
   property p_addr_write;
      $changed(O_MACHINE_ADDR) |-> $past(O_PREADY && I_PWRITE && I_PADDR == `REG_MACH_ADDR);
   endproperty
   a_addr_write: assert property (p_addr_write) else $error("address changed alone");
endmodule

// ==== verif/testbench.sv ====
// self-checking bench for the cascaded regulator with a loop partner
// assumes the design files and pid_params.svh are on the include path
`timescale 1ns/100ps
`include "pid_params.svh"
module testbench;
   localparam int SC = 20;
   typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e;} row_s;
   logic               clk, rst_n, psel, penable, pwrite, pready, err, mod_valid, irq, hold, rerr;
   logic [7:0]         paddr, alarm, maddr, pwr;
   logic [31:0]        pwdata, prdata, rd;
   logic signed [15:0] vout, iout, vset, iset, mod;
   logic [15:0]        mains, dcbus, temp;
   int                 n_mismatch, total_checks;
   row_s rows [0:17] = '{'{0, 8'h08, 0, 32'h64}, '{0, 8'h14, 0, 32'h64}, '{0, 8'h50, 0, 32'h1},
      '{0, 8'h4c, 0, 0}, '{0, 8'h58, 0, 32'h123}, '{0, 8'h5c, 0, 32'h2a0}, '{0, 8'h60, 0, 32'h41},
      '{1, 8'h08, 32'h4e20, 32'h2710}, '{1, 8'h0c, 32'h1e, 32'h32}, '{1, 8'h0c, 0, 0},
      '{1, 8'h10, 32'h9c40, 32'h7d00}, '{1, 8'h14, 32'hc8, 32'h64}, '{1, 8'h4c, 32'h32, 32'h32},
      '{1, 8'h48, 32'h96, 32'h64}, '{1, 8'h04, 32'h8000, 32'hffff8000}, '{1, 8'h50, 5, 5},
      '{1, 8'h54, 7, 7}, '{1, 8'h58, 32'hffff, 32'h123}};
   row_s cfg [0:8] = '{'{1, 8'h08, 128, 0}, '{1, 8'h0c, 0, 0}, '{1, 8'h10, 0, 0},
      '{1, 8'h28, 256, 0}, '{1, 8'h2c, 0, 0}, '{1, 8'h30, 0, 0}, '{1, 8'h48, 0, 0},
      '{1, 8'h04, 2000, 0}, '{1, 8'h00, 1, 0}};
   cascaded_pid_regulator #(.SAMPLE_CYCLES(SC)) cascaded_pid_regulator_inst (.I_MCLK(clk),
      .I_RST_N(rst_n), .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr),
      .I_PWDATA(pwdata), .I_VOUT(vout), .I_IOUT(iout), .I_MAINS_V(mains), .I_DCBUS_V(dcbus),
      .I_HS_TEMP(temp), .I_ALARM(alarm), .O_PREADY(pready), .O_PRDATA(prdata), .O_PSLVERR(err),
      .O_MOD(mod), .O_MOD_VALID(mod_valid), .O_MACHINE_ADDR(maddr), .O_POWER_ADDR(pwr),
      .O_IRQ(irq));
   pwm_stage_model pwm_stage_model_inst (.i_clk(clk), .i_mod(mod), .i_valid(mod_valid),
      .i_hold(hold), .i_vset(vset), .i_iset(iset), .o_vout(vout), .o_iout(iout));
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // look at the answer while it stands, release after the edge that takes it
      do begin
         @(negedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) n_mismatch++;
      rd = prdata;
      rerr = err;
      @(posedge clk);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wait_upd(input int cnt);
      int k;
      repeat (cnt) begin
         k = 0;
         do begin
            @(posedge clk);
            k++;
         end while (mod_valid !== 1'b1 && k < 4 * SC);
         if (mod_valid !== 1'b1) n_mismatch++;
      end
   endtask
   task automatic print_verdict;
      if (n_mismatch == 0 && total_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   initial begin
      repeat (40000) @(posedge clk);
      n_mismatch++;
      print_verdict();
   end
   initial begin
      {rst_n, psel, penable, pwrite, paddr, pwdata, alarm, hold} = '0;
      {vset, iset, mains, dcbus, temp} = {16'sh1f4, 16'sh3e8, 16'h123, 16'h2a0, 16'h41};
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      foreach (rows[i]) begin
         if (rows[i].w) apb(1'b1, rows[i].a, rows[i].d);
         apb(1'b0, rows[i].a, 0);
         check("reg", rd, rows[i].e);
      end
      check("maddr", {24'h0, maddr}, 5);
      check("paddr", {24'h0, pwr}, 7);
      apb(1'b0, 8'h78, 0);
      check("unmapped", rd, 0);
      check("slverr", {31'h0, rerr}, 1);
      foreach (cfg[i]) apb(1'b1, cfg[i].a, cfg[i].d);
      wait_upd(6);
      hold <= 1'b1;
      wait_upd(12);
      apb(1'b0, `REG_CUR_REF, 0);
      check("cur_ref", rd, 1500);
      wait_upd(1);
      check("mod", {16'h0, mod}, 1000);
      iset <= 16'sh64;
      apb(1'b1, `REG_ZTR_GAIN, 16);
      apb(1'b1, `REG_ZTR_AMP, 100);
      wait_upd(3);
      check("ztr", {16'h0, mod}, 4200);
      apb(1'b1, `REG_ZTR_AMP, 0);
      wait_upd(2);
      check("ztr_amp", {16'h0, mod}, 2800);
      apb(1'b1, 8'h2c, 50);
      wait_upd(30);
      check("int_sat", {16'h0, mod}, 32'h7fff);
      apb(1'b1, 8'h34, 0);
      apb(1'b1, 8'h38, 0);
      wait_upd(3);
      check("int_clamp", {16'h0, mod}, 2800);
      apb(1'b1, `REG_IRQ_ENABLE, 32'h21);
      alarm <= 8'h21;
      @(posedge clk);
      alarm <= 8'h0;
      repeat (3) @(posedge clk);
      check("irq_set", {31'h0, irq}, 1);
      apb(1'b1, `REG_IRQ_CLEAR, 32'h1ff);
      apb(1'b0, `REG_IRQ_STATUS, 0);
      check("latched", {24'h0, rd[7:0]}, 32'h20);
      check("irq_kept", {31'h0, irq}, 1);
      apb(1'b1, `REG_IRQ_ENABLE, 32'h1);
      repeat (2) @(posedge clk);
      check("irq_mask", {31'h0, irq}, 0);
      rst_n <= 1'b0;
      @(posedge clk);
      check("rst_addr", {24'h0, maddr}, 1);
      check("rst_pwr", {24'h0, pwr}, 1);
      check("rst_mod", {16'h0, mod}, 0);
      rst_n <= 1'b1;
      @(posedge clk);
      apb(1'b0, `REG_MACH_ADDR, 0);
      check("rel_addr", rd, 1);
      print_verdict();
   end
endmodule
bind cascaded_pid_regulator pid_regulator_monitor #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) mon_inst (
   .I_MCLK(I_MCLK), .I_RST_N(I_RST_N), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE),
   .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA), .I_VOUT(I_VOUT), .I_IOUT(I_IOUT),
   .I_MAINS_V(I_MAINS_V), .I_DCBUS_V(I_DCBUS_V), .I_HS_TEMP(I_HS_TEMP), .I_ALARM(I_ALARM),
   .O_PREADY(O_PREADY), .O_PRDATA(O_PRDATA), .O_PSLVERR(O_PSLVERR), .O_MOD(O_MOD),
   .O_MOD_VALID(O_MOD_VALID), .O_MACHINE_ADDR(O_MACHINE_ADDR), .O_POWER_ADDR(O_POWER_ADDR),
   .O_IRQ(O_IRQ));
